// [verilog/tme_cfg.svh]
/*
 * Constants for the TLB maintenance engine: field widths and defaults.
 * Assumes it is included by the package and the engine by its bare name.
 */
`ifndef TME_CFG_SVH
`define TME_CFG_SVH
// ==========================================================
// Widths
`define TME_BANKS   8
`define TME_BANK_W  3
`define TME_VMID_W  16
`define TME_ASID_W  16
`define TME_ADDR_W  48
`define TME_TXN_W   8
// ==========================================================
// Defaults and fixed values
`define TME_BTM_DEF 1'b1
`define TME_GSEC_NS 0
`define TME_GSEC_S  1
`define TME_NSEC    2
`endif

// [verilog/tme_pkg.sv]
/*
 * Types shared by the TLB maintenance engine and its surroundings.
 * Assumes tme_cfg.svh is on the include path.
 */
`include "tme_cfg.svh"
package tme_pkg;
    // ======================================================
    // Invalidate operations, context space then global space
    typedef enum logic [4:0] {
        TME_OP_CTX_ALL       = 5'h00,
        TME_OP_CTX_ASID      = 5'h01,
        TME_OP_CTX_VA        = 5'h02,
        TME_OP_CTX_VA_ANY    = 5'h03,
        TME_OP_CTX_VA_LAST   = 5'h04,
        TME_OP_CTX_VAA_LAST  = 5'h05,
        TME_OP_CTX_IPA       = 5'h06,
        TME_OP_CTX_IPA_LAST  = 5'h07,
        TME_OP_ALL_NSEC_NHYP = 5'h08,
        TME_OP_SEC_ALL       = 5'h09,
        TME_OP_SEC_ALL_MON   = 5'h0A,
        TME_OP_HYP_ALL       = 5'h0B,
        TME_OP_HYP_VA        = 5'h0C,
        TME_OP_HYP_VA_LAST   = 5'h0D,
        TME_OP_VM_TAG        = 5'h0E,
        TME_OP_VM_TAG_S1     = 5'h0F,
        TME_OP_FLUSH         = 5'h10
    } tme_op_t;

    // ======================================================
    // Engine states
    typedef enum logic [1:0] {
        TME_ST_IDLE  = 2'h0,
        TME_ST_ISSUE = 2'h1,
        TME_ST_WAIT  = 2'h2,
        TME_ST_DRAIN = 2'h3
    } tme_st_t;

    // ======================================================
    // Posted request from registers or a broadcast message
    typedef struct packed {
        logic                   valid;
        logic                   glob;
        logic                   sec;
        logic [`TME_BANK_W-1:0] bank;
        tme_op_t                op;
        logic [`TME_VMID_W-1:0] vmid;
        logic [`TME_ASID_W-1:0] asid;
        logic [`TME_ADDR_W-1:0] addr;
    } tme_req_t;

    // Command to the TLB array
    typedef struct packed {
        tme_op_t                op;
        logic                   sec;
        logic [`TME_BANKS-1:0]  banks;
        logic [`TME_VMID_W-1:0] vmid;
        logic [`TME_ASID_W-1:0] asid;
        logic [`TME_ADDR_W-1:0] addr;
        logic                   s1;
        logic                   s2;
        logic                   walk;
        logic                   page;
    } tme_cmd_t;
endpackage

// [verilog/tme_engine.sv]
/*
 * TLB maintenance engine: posts register and broadcast invalidates,
 * drives them into the TLB array one at a time and tracks sync requests.
 * Assumes the register decoder, broadcast receiver, TLB array and the
 * transaction tracker all run on mclk_i.
 */
// What this block does
// - Report broadcast support as read-only flag
// - VMID hint drops broadcasts carrying a VMID
// - Broadcast non-secure non-hyp all always applies
// - VMID hint never affects secure broadcasts
// - ASID hint excludes that bank from broadcasts carrying an ASID
// - Context writes start stage 1 invalidates
// - Context writes start stage 2 IPA invalidates
// - Context sync trigger and per-bank status
// - Global writes start device-wide invalidates
// - Global sync covers its security state's banks
// - Global status clears after all earlier invalidates
// - Table and stage 2 entries may be cached
// - Context stage 1 invalidates whole page copies
// - Global invalidates hit stage 1 information
// - Non-sec all and VM tag hit stage 2
// - Posting never implies completion; sync confirms
// - Complete after discard and in-flight drain
// - Nested descriptor fetch counts as one transaction
// - Accept unbounded requests without client progress
// - Bank sync covers bank; global covers all
// - Separate tracking per bank and security state
`timescale 1ns/1ps
`default_nettype none
`include "tme_cfg.svh"

module tme_engine #(
    parameter logic BROADCAST_SUPPORT = `TME_BTM_DEF,
    parameter int   TXN_W             = `TME_TXN_W
) (
    input  wire logic                     mclk_i,
    input  wire logic                     rst_n_i,
    input  wire tme_pkg::tme_req_t        reg_req_i,
    input  wire tme_pkg::tme_req_t        dvm_req_i,
    input  wire logic [`TME_BANKS-1:0]    context_sync_trigger_i,
    input  wire logic [`TME_NSEC-1:0]     global_sync_trigger_i,
    input  wire logic                     private_vmid_hint_i,
    input  wire logic [`TME_BANKS-1:0]    private_asid_hint_i,
    input  wire logic                     tlb_cmd_ready_i,
    input  wire logic                     tlb_done_i,
    input  wire logic                     txn_start_i,
    input  wire logic                     txn_observed_i,
    output logic                          broadcast_support_flag_o,
    output tme_pkg::tme_cmd_t             tlb_cmd_o,
    output logic                          tlb_cmd_valid_o,
    output logic [`TME_BANKS-1:0]         context_sync_status_o,
    output logic [`TME_NSEC-1:0]          global_sync_status_o
);
    import tme_pkg::*;

    // ======================================================
    // Sources: banks first, then global non-secure, global secure,
    // and the broadcast receiver last
    localparam int NB    = `TME_BANKS;
    localparam int NSRC  = NB + `TME_NSEC + 1;
    localparam int SRC_W = $clog2(NSRC);
    localparam int DVM   = NB + `TME_NSEC;

    typedef struct packed {
        tme_st_t                    st;
        logic [SRC_W-1:0]           cur;
        logic [NSRC-1:0]            pv;
        tme_cmd_t [NSRC-1:0]        pend;
        tme_cmd_t                   cmd;
        logic                       cv;
        logic [TXN_W-1:0]           infl;
        logic [TXN_W-1:0]           snap;
        logic [NB-1:0]              csync;
        logic [`TME_NSEC-1:0]       gsync;
        logic                       flag;
    } tme_state_t;

    tme_state_t s;
    tme_state_t next_s;

    // ======================================================
    // Helpers
    // A second post to a busy slot widens it to a full flush: over-
    // invalidating is always legal and needs no queue storage.
    function automatic tme_cmd_t tme_merge(input logic busy, input tme_cmd_t c);
        tme_cmd_t r;
        r = c;
        if (busy) begin
            r       = '0;
            r.op    = TME_OP_FLUSH;
            r.banks = '1;
        end
        return r;
    endfunction

    // Scope bits that tell the array which cached structures to hit
    function automatic tme_cmd_t tme_scope(input tme_cmd_t c);
        tme_cmd_t r;
        logic     ipa;
        logic     last;
        r    = c;
        ipa  = (c.op == TME_OP_CTX_IPA) || (c.op == TME_OP_CTX_IPA_LAST);
        last = (c.op == TME_OP_CTX_VA_LAST) || (c.op == TME_OP_CTX_VAA_LAST)
            || (c.op == TME_OP_CTX_IPA_LAST) || (c.op == TME_OP_HYP_VA_LAST);
        r.s1   = !ipa;
        r.s2   = ipa || (c.op == TME_OP_ALL_NSEC_NHYP)
              || (c.op == TME_OP_VM_TAG) || (c.op == TME_OP_FLUSH);
        r.walk = !last;
        r.page = (c.op >= TME_OP_CTX_VA) && (c.op <= TME_OP_CTX_VAA_LAST);
        return r;
    endfunction

    // ======================================================
    // Next-state logic
    always_comb begin
        tme_cmd_t         rc;
        tme_cmd_t         dc;
        logic             rok;
        logic             has_vmid;
        logic             has_asid;
        logic             found;
        logic [SRC_W-1:0] sel;
        logic [SRC_W-1:0] ridx;
        logic             serving;
        logic             any_busy;
        rc       = '0;
        dc       = '0;
        rok      = 1'b0;
        has_vmid = 1'b0;
        has_asid = 1'b0;
        found    = 1'b0;
        sel      = '0;
        ridx     = '0;
        next_s   = s;

        next_s.flag = BROADCAST_SUPPORT;

        // Pick the lowest pending source when the engine is free
        for (int i = 0; i < NSRC; i++) begin
            if (!found && s.pv[i]) begin
                found = 1'b1;
                sel   = SRC_W'(i);
            end
        end

        // Transaction counter; the tracker reports a nested stage 1
        // descriptor fetch as one start and one observation
        next_s.infl = s.infl + TXN_W'(txn_start_i) - TXN_W'(txn_observed_i);

        // Service sequence: issue, wait for discard, drain in-flight
        unique case (s.st)
            TME_ST_IDLE: begin
                if (found) begin
                    next_s.cmd      = tme_scope(s.pend[sel]);
                    next_s.pv[sel]  = 1'b0;
                    next_s.cur      = sel;
                    next_s.cv       = 1'b1;
                    next_s.st       = TME_ST_ISSUE;
                end
            end
            TME_ST_ISSUE: begin
                if (tlb_cmd_ready_i) begin
                    next_s.cv = 1'b0;
                    next_s.st = TME_ST_WAIT;
                end
            end
            TME_ST_WAIT: begin
                // Only transactions already in flight can hold old entries
                if (tlb_done_i) begin
                    next_s.snap = next_s.infl;
                    next_s.st   = TME_ST_DRAIN;
                end
            end
            TME_ST_DRAIN: begin
                if (s.snap == '0) begin
                    next_s.st = TME_ST_IDLE;
                end else if (txn_observed_i) begin
                    next_s.snap = s.snap - TXN_W'(1);
                end
            end
        endcase

        // Register post: context ops only in a bank, global ops only global
        rok = reg_req_i.valid
           && (reg_req_i.glob == (reg_req_i.op >= TME_OP_ALL_NSEC_NHYP))
           && (reg_req_i.op != TME_OP_FLUSH);
        rc.op    = reg_req_i.op;
        rc.sec   = reg_req_i.sec;
        rc.vmid  = reg_req_i.vmid;
        rc.asid  = reg_req_i.asid;
        rc.addr  = reg_req_i.addr;
        rc.banks = reg_req_i.glob ? '1 : (NB'(1) << reg_req_i.bank);
        ridx     = reg_req_i.glob ? SRC_W'(NB + 32'(reg_req_i.sec))
                                  : SRC_W'(reg_req_i.bank);
        // Posting only records the work; nothing here signals completion
        if (rok) begin
            next_s.pend[ridx] = tme_merge(next_s.pv[ridx], rc);
            next_s.pv[ridx]   = 1'b1;
        end

        // Broadcast post, filtered by the namespace hints
        has_vmid = !dvm_req_i.sec && (dvm_req_i.op != TME_OP_ALL_NSEC_NHYP)
                && ((dvm_req_i.op <= TME_OP_CTX_IPA_LAST)
                 || (dvm_req_i.op == TME_OP_VM_TAG)
                 || (dvm_req_i.op == TME_OP_VM_TAG_S1));
        has_asid = (dvm_req_i.op == TME_OP_CTX_ASID)
                || (dvm_req_i.op == TME_OP_CTX_VA)
                || (dvm_req_i.op == TME_OP_CTX_VA_LAST);
        dc.op    = dvm_req_i.op;
        dc.sec   = dvm_req_i.sec;
        dc.vmid  = dvm_req_i.vmid;
        dc.asid  = dvm_req_i.asid;
        dc.addr  = dvm_req_i.addr;
        dc.banks = has_asid ? ~private_asid_hint_i : '1;
        if (s.flag && dvm_req_i.valid && (dvm_req_i.op != TME_OP_FLUSH)
            && !(private_vmid_hint_i && has_vmid)
            && (dc.banks != '0)) begin
            next_s.pend[DVM] = tme_merge(next_s.pv[DVM], dc);
            next_s.pv[DVM]   = 1'b1;
        end

        // Sync tracking; a trigger in the clearing cycle wins
        serving  = (s.st != TME_ST_IDLE);
        any_busy = (s.pv != '0) || serving;
        for (int b = 0; b < NB; b++) begin
            next_s.csync[b] = context_sync_trigger_i[b]
                || (s.csync[b] && (s.pv[b]
                    || (serving && (s.cur == SRC_W'(b)))));
        end
        // Global sync waits on every source, both security states
        for (int k = 0; k < `TME_NSEC; k++) begin
            next_s.gsync[k] = global_sync_trigger_i[k]
                || (s.gsync[k] && any_busy);
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s      <= '0;
            s.flag <= BROADCAST_SUPPORT;
        end else begin
            s <= next_s;
        end
    end

    // ======================================================
    // Outputs straight from the state register
    assign broadcast_support_flag_o = s.flag;
    assign tlb_cmd_o                = s.cmd;
    assign tlb_cmd_valid_o          = s.cv;
    assign context_sync_status_o    = s.csync;
    assign global_sync_status_o     = s.gsync;

endmodule // tme_engine
`default_nettype wire

// [testbench/tme_engine_chk.sv]
/*
 * Port checker for tme_engine, bound to every instance.
 * Assumes tme_pkg is compiled first and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tme_cfg.svh"
module tme_engine_chk import tme_pkg::*; #(
    parameter logic BROADCAST_SUPPORT = 1'b1
) (
    input wire logic                  mclk_i,
    input wire logic                  rst_n_i,
    input wire tme_pkg::tme_req_t     reg_req_i,
    input wire logic [`TME_BANKS-1:0] context_sync_trigger_i,
    input wire logic [`TME_NSEC-1:0]  global_sync_trigger_i,
    input wire logic                  tlb_cmd_ready_i,
    input wire logic                  tlb_done_i,
    input wire logic                  broadcast_support_flag_o,
    input wire tme_pkg::tme_cmd_t     tlb_cmd_o,
    input wire logic                  tlb_cmd_valid_o,
    input wire logic [`TME_BANKS-1:0] context_sync_status_o,
    input wire logic [`TME_NSEC-1:0]  global_sync_status_o
);
    // ==========================================================
    // Taken command still waiting for its discard report
    logic wait_done;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || tlb_done_i) begin
            wait_done <= 1'b0;
        end else if (tlb_cmd_valid_o && tlb_cmd_ready_i) begin
            wait_done <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Assertions
    flag_const_a: assert property (broadcast_support_flag_o == BROADCAST_SUPPORT)
        else $error("support flag differs from parameter");
    reset_quiet_a: assert property ($rose(rst_n_i) |-> !tlb_cmd_valid_o
        && context_sync_status_o == 8'h00 && global_sync_status_o == 2'h0)
        else $error("outputs busy after reset");
    ctx_rise_a: assert property (context_sync_trigger_i != 8'h00 |=>
        (context_sync_status_o & $past(context_sync_trigger_i)) == $past(context_sync_trigger_i))
        else $error("bank sync status not raised");
    glob_rise_a: assert property (global_sync_trigger_i != 2'h0 |=>
        (global_sync_status_o & $past(global_sync_trigger_i)) == $past(global_sync_trigger_i))
        else $error("global sync status not raised");
    cmd_hold_a: assert property (tlb_cmd_valid_o && !tlb_cmd_ready_i |=>
        tlb_cmd_valid_o && $stable(tlb_cmd_o))
        else $error("command changed before taken");
    glob_busy_a: assert property (tlb_cmd_valid_o || (wait_done && !tlb_done_i) |=>
        (global_sync_status_o & $past(global_sync_status_o)) == $past(global_sync_status_o))
        else $error("global sync ended during service");
    post_cmd_a: assert property (reg_req_i.valid && !reg_req_i.glob
        && reg_req_i.op <= TME_OP_CTX_IPA_LAST |-> ##[2:1000] tlb_cmd_valid_o)
        else $error("context post never issued");
    va_scope_a: assert property (tlb_cmd_valid_o && tlb_cmd_o.op == TME_OP_CTX_VA |->
        tlb_cmd_o.s1 && tlb_cmd_o.page)
        else $error("address invalidate lacks page scope");
    s2_scope_a: assert property (tlb_cmd_valid_o && (tlb_cmd_o.op == TME_OP_ALL_NSEC_NHYP
        || tlb_cmd_o.op == TME_OP_VM_TAG) |-> tlb_cmd_o.s2)
        else $error("stage 2 scope missing");
    // Main scenarios seen
    stall_c: cover property (tlb_cmd_valid_o && !tlb_cmd_ready_i);
    gdone_c: cover property (global_sync_status_o != 2'h0 ##1 global_sync_status_o == 2'h0);
    cdone_c: cover property (context_sync_status_o != 8'h00 ##1 context_sync_status_o == 8'h00);
endmodule // tme_engine_chk
bind tme_engine tme_engine_chk #(.BROADCAST_SUPPORT(BROADCAST_SUPPORT)) u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .context_sync_trigger_i(context_sync_trigger_i), .global_sync_trigger_i(global_sync_trigger_i),
    .tlb_cmd_ready_i(tlb_cmd_ready_i), .tlb_done_i(tlb_done_i), .tlb_cmd_o(tlb_cmd_o),
    .broadcast_support_flag_o(broadcast_support_flag_o), .tlb_cmd_valid_o(tlb_cmd_valid_o),
    .context_sync_status_o(context_sync_status_o), .global_sync_status_o(global_sync_status_o));
`default_nettype wire

// [testbench/tme_tlb_model.sv]
/*
 * TLB array model: takes one command, reports its discard later.
 * Assumes the engine waits for the discard before its next command.
 */
`timescale 1ns/1ps
`default_nettype none
module tme_tlb_model (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic cmd_valid_i,
    input  wire logic slow_i,
    output logic      ready_o,
    output logic      done_o
);
    int wait_cnt;
    int done_cnt;
    // Slow mode stalls ready so the engine must hold its command
    always @(posedge mclk_i) begin
        done_o <= 1'b0;
        if (!rst_n_i) begin
            ready_o  <= 1'b0;
            wait_cnt <= 0;
            done_cnt <= 0;
        end else begin
            if (done_cnt == 1) done_o <= 1'b1;
            if (done_cnt != 0) done_cnt <= done_cnt - 1;
            // The stall count is loaded at each take, so slow mode really
            // holds ready low for the next command before raising it
            if (cmd_valid_i && ready_o) begin
                ready_o  <= 1'b0;
                done_cnt <= 4;
                wait_cnt <= slow_i ? 6 : 0;
            end else if (cmd_valid_i && done_cnt == 0 && wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end else if (cmd_valid_i && done_cnt == 0) begin
                ready_o  <= 1'b1;
            end
        end
    end
endmodule // tme_tlb_model
`default_nettype wire

// [testbench/tlb_maintenance_engine_bench.sv]
/*
 * Self-checking bench for tme_engine with the TLB array model.
 * Assumes the checker and model files are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tlb_maintenance_engine_bench;
    import tme_pkg::*;
    typedef struct packed {logic chk; logic [7:0] banks; tme_op_t op;} tme_exp_t;
    logic       mclk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    tme_req_t   reg_req_i = '0;
    tme_req_t   dvm_req_i = '0;
    logic [7:0] context_sync_trigger_i = 8'h00;
    logic [1:0] global_sync_trigger_i = 2'h0;
    logic       private_vmid_hint_i = 1'b0;
    logic [7:0] private_asid_hint_i = 8'h00;
    logic       txn_start_i = 1'b0;
    logic       txn_observed_i = 1'b0;
    logic       slow = 1'b0;
    logic       tlb_cmd_ready_i, tlb_done_i, broadcast_support_flag_o, tlb_cmd_valid_o;
    logic [7:0] context_sync_status_o;
    logic [1:0] global_sync_status_o;
    tme_cmd_t   tlb_cmd_o;
    tme_exp_t   exp_q[$];
    tme_exp_t   got;
    tme_req_t   rq;
    int         err_total = 0;
    int         cmp_count = 0;

    tme_engine #(.BROADCAST_SUPPORT(1'b1)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .reg_req_i(reg_req_i), .dvm_req_i(dvm_req_i),
        .context_sync_trigger_i(context_sync_trigger_i), .global_sync_trigger_i(global_sync_trigger_i),
        .private_vmid_hint_i(private_vmid_hint_i), .private_asid_hint_i(private_asid_hint_i),
        .tlb_cmd_ready_i(tlb_cmd_ready_i), .tlb_done_i(tlb_done_i), .txn_start_i(txn_start_i),
        .txn_observed_i(txn_observed_i), .broadcast_support_flag_o(broadcast_support_flag_o),
        .tlb_cmd_o(tlb_cmd_o), .tlb_cmd_valid_o(tlb_cmd_valid_o),
        .context_sync_status_o(context_sync_status_o), .global_sync_status_o(global_sync_status_o));
    tme_tlb_model u_tlb (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(tlb_cmd_valid_o),
        .slow_i(slow), .ready_o(tlb_cmd_ready_i), .done_o(tlb_done_i));

    // ==========================================================
    // Clock, comparison and closing
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Each command the array takes must match the oldest note; looked at
    // mid-cycle so the handshake is settled, not racing the clock edge
    always @(negedge mclk_i) begin
        if (rst_n_i && tlb_cmd_valid_o === 1'b1 && tlb_cmd_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(1'b0, "unexpected command");
            end else begin
                got = exp_q.pop_front();
                check(tlb_cmd_o.op === got.op && (!got.chk || tlb_cmd_o.banks === got.banks),
                      "command differs");
            end
        end
    end
    // Post, sync its space, optionally hold one transaction, poll the sync
    task automatic post_sync(input tme_req_t r, input logic dvm, input logic hit, input logic hold);
        int n;
        if (hit) exp_q.push_back('{!r.glob && !dvm, 8'h01 << r.bank, r.op});
        @(posedge mclk_i);
        if (dvm) dvm_req_i <= r;
        else reg_req_i <= r;
        @(posedge mclk_i);
        reg_req_i.valid <= 1'b0;
        dvm_req_i.valid <= 1'b0;
        if (r.glob || dvm) global_sync_trigger_i <= 2'h1 << r.sec;
        else context_sync_trigger_i <= 8'h01 << r.bank;
        @(posedge mclk_i);
        context_sync_trigger_i <= 8'h00;
        global_sync_trigger_i <= 2'h0;
        #1;
        check(|{context_sync_status_o, global_sync_status_o}, "sync not raised");
        n = 0;
        while (hold && tlb_done_i !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (hold) begin
            repeat (3) @(posedge mclk_i);
            #1;
            check(|context_sync_status_o, "sync ended before drain");
            @(posedge mclk_i);
            txn_observed_i <= 1'b1;
            @(posedge mclk_i);
            txn_observed_i <= 1'b0;
        end
        n = 0;
        while (|{context_sync_status_o, global_sync_status_o} && n < 300) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check(n < 300, "sync never finished");
        check(exp_q.size() == 0, "sync finished before command");
    endtask
    function automatic tme_req_t mk(input logic g, input logic s, input int op);
        return '{1'b1, g, s, 3'($urandom_range(7)), tme_op_t'(op), 16'($urandom),
                 16'($urandom), {16'($urandom), 32'($urandom)}};
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h629B0135));
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        check(broadcast_support_flag_o === 1'b1, "support flag wrong");
        check({context_sync_status_o, global_sync_status_o, tlb_cmd_valid_o} === 11'h000,
              "busy after reset");
        for (int i = 0; i < 8; i++) begin
            slow <= i[0];
            post_sync(mk(1'b0, 1'b0, i), 1'b0, 1'b1, 1'b0);
        end
        for (int i = 8; i < 16; i++) begin
            post_sync(mk(1'b1, 1'($urandom_range(1)), i), 1'b0, 1'b1, 1'b0);
        end
        post_sync(mk(1'b0, 1'b0, 14), 1'b0, 1'b0, 1'b0);
        private_vmid_hint_i <= 1'b1;
        post_sync(mk(1'b1, 1'b0, 14), 1'b1, 1'b0, 1'b0);
        post_sync(mk(1'b1, 1'b0, 8), 1'b1, 1'b1, 1'b0);
        post_sync(mk(1'b1, 1'b1, 9), 1'b1, 1'b1, 1'b0);
        private_asid_hint_i <= 8'hFF;
        post_sync(mk(1'b1, 1'b0, 1), 1'b1, 1'b0, 1'b0);
        private_vmid_hint_i <= 1'b0;
        private_asid_hint_i <= 8'h00;
        @(posedge mclk_i);
        txn_start_i <= 1'b1;
        @(posedge mclk_i);
        txn_start_i <= 1'b0;
        post_sync(mk(1'b0, 1'b0, 2), 1'b0, 1'b1, 1'b1);
        end_of_test();
    end
    // Watchdog well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end
endmodule // tlb_maintenance_engine_bench
`default_nettype wire
